/* include/pin_function_pkg.sv */
// holds constants for the port 1 pins 0..4 function select block
// assumes an APB master with 32-bit data and one aligned word per register
//----------------------------------------------------------------------
// Overview of operation
// - config bit 0 set routes the pin to general I/O.
// - all config registers reset to zero; every function starts off.
// - bit 1 set adds the pin to pin-interrupt group A sources.
// - bit 2 set adds the pin to pin-interrupt group B sources.
// - each interrupt group combines all pins whose group bit is set.
// - one pin may feed both interrupt groups at once.
// - bit 5 on pins 0 and 2 drives motor PWM A positive.
// - bit 5 on pins 1 and 3 drives motor PWM A negative.
// - bit 5 on pin 4 drives motor PWM B positive.
// - bit 4 on pins 0..3 is capture/compare line 0..3.
// - bit 4 on pin 4 is the I2C master clock line.
// - bit 6 makes pin 2 slave-one data and pin 3 slave-one clock.
// - bit 6 on pin 4 is the slave-two clock line.
// - bit 7 on pins 0..3 routes the pin to an ADC D input.
// - bit 7 on pin 4 routes the RTC crystal output.
//----------------------------------------------------------------------
package pin_function_pkg;

  // geometry
  localparam int NUM_PINS = 5;
  localparam int CFG_W    = 8;
  localparam int DATA_W   = 32;
  localparam int ADDR_W   = 32;
  localparam int PIN_IDX_W = 3;

  // reset value of every config register
  localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;

  // field positions inside a config register
  localparam int GENERAL_IO_BIT = 0;
  localparam int GRP_A_BIT      = 1;
  localparam int GRP_B_BIT      = 2;
  localparam int ALT_LOW_BIT    = 4;
  localparam int MOTOR_PWM_BIT  = 5;
  localparam int SLAVE_BIT      = 6;
  localparam int ANALOG_BIT     = 7;

  // register indices; byte address is the index times four
  localparam int WORD_SHIFT = 2;
  localparam logic [15:0] REG_IDX [NUM_PINS] = '{16'hA058, 16'hA059, 16'hA05A, 16'hA05B, 16'hA05C};

  // implemented bits per pin, bit 3 never, bit 6 only on pins 2..4
  localparam logic [CFG_W-1:0] IMPL_MASK [NUM_PINS] = '{8'hB7, 8'hB7, 8'hF7, 8'hF7, 8'hF7};

  // pins with a special role
  localparam int SLAVE1_DATA_PIN = 2;
  localparam int SLAVE1_CLK_PIN  = 3;
  localparam int TOP_PIN         = 4;

  // level a routed-off I2C input shows, an idle released bus
  localparam logic I2C_IDLE = 1'b1;

  // read data above the register width
  localparam logic [DATA_W-CFG_W-1:0] READ_PAD = 24'h000000;

endpackage

/* core/port1_low_pin_function_select.sv */
// function select for port 1 pins 0..4: config registers and pad routing
// assumes APB master on clock_i, peripherals supply drive and take pad inputs
module port1_low_pin_function_select (
  // clock and reset
  input  wire logic                                  clock_i,
  input  wire logic                                  reset_n_i,
  // apb slave
  input  wire logic                                  psel_i,
  input  wire logic                                  penable_i,
  input  wire logic                                  pwrite_i,
  input  wire logic [pin_function_pkg::ADDR_W-1:0]   paddr_i,
  input  wire logic [pin_function_pkg::DATA_W-1:0]   pwdata_i,
  input  wire logic [3:0]                            pstrb_i,
  output logic                                       pready_o,
  output logic                                       pslverr_o,
  output logic [pin_function_pkg::DATA_W-1:0]        prdata_o,
  // pads
  input  wire logic [pin_function_pkg::NUM_PINS-1:0] pad_in_i,
  output logic [pin_function_pkg::NUM_PINS-1:0]      pad_out_o,
  output logic [pin_function_pkg::NUM_PINS-1:0]      pad_oe_o,
  // general io
  input  wire logic [pin_function_pkg::NUM_PINS-1:0] general_io_out_i,
  input  wire logic [pin_function_pkg::NUM_PINS-1:0] general_io_oe_i,
  output logic [pin_function_pkg::NUM_PINS-1:0]      general_io_in_o,
  // pin interrupt groups
  output logic [pin_function_pkg::NUM_PINS-1:0]      pin_irq_group_a_src_o,
  output logic [pin_function_pkg::NUM_PINS-1:0]      pin_irq_group_b_src_o,
  output logic                                       pin_irq_group_a_o,
  output logic                                       pin_irq_group_b_o,
  // motor pwm unit
  input  wire logic                                  motor_pwm_a_pos_i,
  input  wire logic                                  motor_pwm_a_neg_i,
  input  wire logic                                  motor_pwm_b_pos_i,
  // capture/compare channels 0..3
  input  wire logic [3:0]                            capcmp_out_i,
  input  wire logic [3:0]                            capcmp_oe_i,
  output logic [3:0]                                 capcmp_in_o,
  // i2c lines, *_low_i high means pull the line low
  input  wire logic                                  master_clock_low_i,
  output logic                                       master_clock_in_o,
  input  wire logic                                  slave1_data_low_i,
  output logic                                       slave1_data_in_o,
  input  wire logic                                  slave1_clock_low_i,
  output logic                                       slave1_clock_in_o,
  input  wire logic                                  slave2_clock_low_i,
  output logic                                       slave2_clock_in_o,
  // analog routing
  output logic [3:0]                                 adc_d_select_o,
  output logic                                       rtc_crystal_out_select_o
);

  //--------------------------------------------------------------------
  // address decode
  //--------------------------------------------------------------------

  // maps a byte address to a pin number, NUM_PINS when unmapped
  // the whole address takes part in the match, so there are no aliases
  function automatic logic [pin_function_pkg::PIN_IDX_W-1:0] addr_to_pin(
    input logic [pin_function_pkg::ADDR_W-1:0] addr
  );
    logic [pin_function_pkg::PIN_IDX_W-1:0] hit;
    hit = pin_function_pkg::PIN_IDX_W'(pin_function_pkg::NUM_PINS);
    for (int p = 0; p < pin_function_pkg::NUM_PINS; p++) begin
      if (addr == (pin_function_pkg::ADDR_W'(pin_function_pkg::REG_IDX[p]) << pin_function_pkg::WORD_SHIFT)) begin
        hit = pin_function_pkg::PIN_IDX_W'(p);
      end
    end
    return hit;
  endfunction

  logic [pin_function_pkg::PIN_IDX_W-1:0] sel_pin;
  logic                                   sel_hit;

  // decoded once, shared by read and write paths
  always_comb begin
    sel_pin = addr_to_pin(paddr_i);
    sel_hit = (sel_pin != pin_function_pkg::PIN_IDX_W'(pin_function_pkg::NUM_PINS));
  end

  logic                                  access_ph;
  logic [pin_function_pkg::NUM_PINS-1:0] wr_hit;

  // access phase of any transfer, shared by the error and write paths
  assign access_ph = psel_i & penable_i;

  // one write strobe per register; lane 0 carries all eight bits,
  // so a write with pstrb_i[0] low leaves every register alone
  generate
    for (genvar p = 0; p < pin_function_pkg::NUM_PINS; p++) begin : g_wr_hit
      assign wr_hit[p] = access_ph & pwrite_i & pstrb_i[0] & sel_hit &
                         (sel_pin == pin_function_pkg::PIN_IDX_W'(p));
    end
  endgenerate

  // zero wait states; unmapped access answers with an error
  // no sideband for the error: software sees only pslverr_o
  assign pready_o  = 1'b1;
  assign pslverr_o = access_ph & ~sel_hit;

  //--------------------------------------------------------------------
  // configuration registers
  //--------------------------------------------------------------------

  logic [pin_function_pkg::CFG_W-1:0] cfg_ff     [pin_function_pkg::NUM_PINS];
  logic [pin_function_pkg::CFG_W-1:0] nxt_cfg    [pin_function_pkg::NUM_PINS];
  logic [pin_function_pkg::DATA_W-1:0] prdata_ff;
  logic [pin_function_pkg::DATA_W-1:0] nxt_prdata;

  // write in the access phase, only lane 0 holds register bits
  always_comb begin
    for (int p = 0; p < pin_function_pkg::NUM_PINS; p++) begin
      nxt_cfg[p] = cfg_ff[p];
      if (wr_hit[p]) begin
        nxt_cfg[p] = pwdata_i[pin_function_pkg::CFG_W-1:0] & pin_function_pkg::IMPL_MASK[p];
      end
    end
  end

  // read data captured in setup so it is ready in the access phase
  // unmapped reads return zero rather than the last value
  always_comb begin
    nxt_prdata = prdata_ff;
    if (psel_i && !penable_i && !pwrite_i) begin
      nxt_prdata = '0;
      if (sel_hit) begin
        nxt_prdata = {pin_function_pkg::READ_PAD, cfg_ff[sel_pin]};
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      for (int p = 0; p < pin_function_pkg::NUM_PINS; p++) begin
        cfg_ff[p] <= pin_function_pkg::CFG_RESET;
      end
      prdata_ff <= '0;
    end else begin
      for (int p = 0; p < pin_function_pkg::NUM_PINS; p++) begin
        cfg_ff[p] <= nxt_cfg[p];
      end
      prdata_ff <= nxt_prdata;
    end
  end

  assign prdata_o = prdata_ff;

  //--------------------------------------------------------------------
  // pad output routing
  //--------------------------------------------------------------------

  logic [pin_function_pkg::NUM_PINS-1:0] pad_out_ff;
  logic [pin_function_pkg::NUM_PINS-1:0] pad_oe_ff;
  logic [pin_function_pkg::NUM_PINS-1:0] nxt_pad_out;
  logic [pin_function_pkg::NUM_PINS-1:0] nxt_pad_oe;

  // priority analog > slave i2c > bit 4 > motor pwm > general io,
  // so a careless double select never lets two drivers fight the pad
  generate
    for (genvar p = 0; p < pin_function_pkg::NUM_PINS; p++) begin : g_drive
      always_comb begin
        nxt_pad_out[p] = 1'b0;
        nxt_pad_oe[p]  = 1'b0;
        if (cfg_ff[p][pin_function_pkg::ANALOG_BIT]) begin
          // pad left undriven for the analog path
          nxt_pad_oe[p] = 1'b0;
        end else if (cfg_ff[p][pin_function_pkg::SLAVE_BIT]) begin
          // open-drain style: only ever drive low
          if (p == pin_function_pkg::SLAVE1_DATA_PIN) begin
            nxt_pad_oe[p] = slave1_data_low_i;
          end else if (p == pin_function_pkg::SLAVE1_CLK_PIN) begin
            nxt_pad_oe[p] = slave1_clock_low_i;
          end else if (p == pin_function_pkg::TOP_PIN) begin
            nxt_pad_oe[p] = slave2_clock_low_i;
          end
        end else if (cfg_ff[p][pin_function_pkg::ALT_LOW_BIT]) begin
          if (p == pin_function_pkg::TOP_PIN) begin
            nxt_pad_oe[p] = master_clock_low_i;
          end else begin
            nxt_pad_out[p] = capcmp_out_i[p % 4];
            nxt_pad_oe[p]  = capcmp_oe_i[p % 4];
          end
        end else if (cfg_ff[p][pin_function_pkg::MOTOR_PWM_BIT]) begin
          nxt_pad_oe[p] = 1'b1;
          if (p == pin_function_pkg::TOP_PIN) begin
            nxt_pad_out[p] = motor_pwm_b_pos_i;
          end else if (p % 2 == 0) begin
            nxt_pad_out[p] = motor_pwm_a_pos_i;
          end else begin
            nxt_pad_out[p] = motor_pwm_a_neg_i;
          end
        end else if (cfg_ff[p][pin_function_pkg::GENERAL_IO_BIT]) begin
          nxt_pad_out[p] = general_io_out_i[p];
          nxt_pad_oe[p]  = general_io_oe_i[p];
        end
      end
    end
  endgenerate

  // registered pads: one cycle of latency, no glitches on select changes
  // trade-off: every driven pin lags its peripheral by one clock
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      pad_out_ff <= '0;
      pad_oe_ff  <= '0;
    end else begin
      pad_out_ff <= nxt_pad_out;
      pad_oe_ff  <= nxt_pad_oe;
    end
  end

  assign pad_out_o = pad_out_ff;
  assign pad_oe_o  = pad_oe_ff;

  //--------------------------------------------------------------------
  // pad input routing
  //--------------------------------------------------------------------

  logic [pin_function_pkg::NUM_PINS-1:0] gio_in_ff, nxt_gio_in;
  logic [pin_function_pkg::NUM_PINS-1:0] grp_a_ff, nxt_grp_a;
  logic [pin_function_pkg::NUM_PINS-1:0] grp_b_ff, nxt_grp_b;
  logic [3:0]                            cap_in_ff, nxt_cap_in;
  logic [3:0]                            adc_sel_ff, nxt_adc_sel;
  logic                                  rtc_sel_ff, nxt_rtc_sel;
  logic                                  mclk_in_ff, nxt_mclk_in;
  logic                                  s1d_in_ff, nxt_s1d_in;
  logic                                  s1c_in_ff, nxt_s1c_in;
  logic                                  s2c_in_ff, nxt_s2c_in;

  // inputs pass one register, so a pin edge reaches its group a cycle late
  // deselected inputs read low; deselected i2c inputs read idle high
  always_comb begin
    for (int p = 0; p < pin_function_pkg::NUM_PINS; p++) begin
      nxt_gio_in[p] = pad_in_i[p] & cfg_ff[p][pin_function_pkg::GENERAL_IO_BIT];
      nxt_grp_a[p]  = pad_in_i[p] & cfg_ff[p][pin_function_pkg::GRP_A_BIT];
      nxt_grp_b[p]  = pad_in_i[p] & cfg_ff[p][pin_function_pkg::GRP_B_BIT];
    end
    for (int c = 0; c < 4; c++) begin
      nxt_cap_in[c]  = pad_in_i[c] & cfg_ff[c][pin_function_pkg::ALT_LOW_BIT];
      nxt_adc_sel[c] = cfg_ff[c][pin_function_pkg::ANALOG_BIT];
    end
    nxt_rtc_sel = cfg_ff[pin_function_pkg::TOP_PIN][pin_function_pkg::ANALOG_BIT];
    nxt_mclk_in = pin_function_pkg::I2C_IDLE;
    nxt_s1d_in  = pin_function_pkg::I2C_IDLE;
    nxt_s1c_in  = pin_function_pkg::I2C_IDLE;
    nxt_s2c_in  = pin_function_pkg::I2C_IDLE;
    if (cfg_ff[pin_function_pkg::TOP_PIN][pin_function_pkg::ALT_LOW_BIT]) begin
      nxt_mclk_in = pad_in_i[pin_function_pkg::TOP_PIN];
    end
    if (cfg_ff[pin_function_pkg::SLAVE1_DATA_PIN][pin_function_pkg::SLAVE_BIT]) begin
      nxt_s1d_in = pad_in_i[pin_function_pkg::SLAVE1_DATA_PIN];
    end
    if (cfg_ff[pin_function_pkg::SLAVE1_CLK_PIN][pin_function_pkg::SLAVE_BIT]) begin
      nxt_s1c_in = pad_in_i[pin_function_pkg::SLAVE1_CLK_PIN];
    end
    if (cfg_ff[pin_function_pkg::TOP_PIN][pin_function_pkg::SLAVE_BIT]) begin
      nxt_s2c_in = pad_in_i[pin_function_pkg::TOP_PIN];
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      gio_in_ff  <= '0;
      grp_a_ff   <= '0;
      grp_b_ff   <= '0;
      cap_in_ff  <= '0;
      adc_sel_ff <= '0;
      rtc_sel_ff <= 1'b0;
      mclk_in_ff <= pin_function_pkg::I2C_IDLE;
      s1d_in_ff  <= pin_function_pkg::I2C_IDLE;
      s1c_in_ff  <= pin_function_pkg::I2C_IDLE;
      s2c_in_ff  <= pin_function_pkg::I2C_IDLE;
    end else begin
      gio_in_ff  <= nxt_gio_in;
      grp_a_ff   <= nxt_grp_a;
      grp_b_ff   <= nxt_grp_b;
      cap_in_ff  <= nxt_cap_in;
      adc_sel_ff <= nxt_adc_sel;
      rtc_sel_ff <= nxt_rtc_sel;
      mclk_in_ff <= nxt_mclk_in;
      s1d_in_ff  <= nxt_s1d_in;
      s1c_in_ff  <= nxt_s1c_in;
      s2c_in_ff  <= nxt_s2c_in;
    end
  end

  // group outputs: any enabled pin that is high raises the group
  // edge or level sensing is left to the interrupt unit
  assign pin_irq_group_a_src_o = grp_a_ff;
  assign pin_irq_group_b_src_o = grp_b_ff;
  assign pin_irq_group_a_o     = |grp_a_ff;
  assign pin_irq_group_b_o     = |grp_b_ff;

  assign general_io_in_o          = gio_in_ff;
  assign capcmp_in_o              = cap_in_ff;
  assign adc_d_select_o           = adc_sel_ff;
  assign rtc_crystal_out_select_o = rtc_sel_ff;
  assign master_clock_in_o        = mclk_in_ff;
  assign slave1_data_in_o         = s1d_in_ff;
  assign slave1_clock_in_o        = s1c_in_ff;
  assign slave2_clock_in_o        = s2c_in_ff;

endmodule

/* tb/pin_select_props.sv */
// checker for the port 1 low pin function select block
// assumes one clock domain and a synchronous active-low reset
module pin_select_props (
  // bus side
  input logic        clock_i, reset_n_i, psel_i, penable_i, pwrite_i,
  input logic [31:0] paddr_i, pwdata_i, prdata_o,
  input logic [3:0]  pstrb_i, capcmp_in_o, adc_d_select_o,
  // pad side
  input logic        pin_irq_group_a_o, motor_pwm_a_pos_i, slave1_data_low_i, rtc_crystal_out_select_o,
  input logic [4:0]  pad_in_i, pad_out_o, pad_oe_o, general_io_in_o, pin_irq_group_a_src_o, pin_irq_group_b_src_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cfg_ff [5];
  logic [7:0] nxt_cfg [5];
  logic [4:0] gio_v, a_v, b_v;
  logic [3:0] cc_v, ad_v;
  logic [7:0] rd_v;
  logic       mapped;
  int         idx;
  // shadow of the config registers, rebuilt from bus writes only
  always_comb begin
    nxt_cfg = cfg_ff;
    mapped = 1'b0;
    idx = 0;
    rd_v = 8'h00;
    for (int p = 0; p < 5; p++) begin
      if (paddr_i == {14'h0000, pin_function_pkg::REG_IDX[p], 2'b00}) begin
        mapped = 1'b1;
        idx = p;
        rd_v = cfg_ff[p];
      end
      gio_v[p] = cfg_ff[p][0];
      a_v[p] = cfg_ff[p][1];
      b_v[p] = cfg_ff[p][2];
    end
    cc_v = {cfg_ff[3][4], cfg_ff[2][4], cfg_ff[1][4], cfg_ff[0][4]};
    ad_v = {cfg_ff[3][7], cfg_ff[2][7], cfg_ff[1][7], cfg_ff[0][7]};
    if (psel_i && penable_i && pwrite_i && pstrb_i[0] && mapped) begin
      nxt_cfg[idx] = pwdata_i[7:0] & pin_function_pkg::IMPL_MASK[idx];
    end
  end
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) cfg_ff <= '{default: 8'h00};
    else cfg_ff <= nxt_cfg;
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_rd_setup; psel_i && !penable_i && !pwrite_i; endsequence
  property p_rd; s_rd_setup |=> prdata_o == {24'h000000, $past(rd_v)}; endproperty
  a_rd: assert property (p_rd) else $error("read data differs from shadow");
  property p_gio; 1'b1 |=> general_io_in_o == $past(pad_in_i & gio_v); endproperty
  a_gio: assert property (p_gio) else $error("general io input wrong");
  property p_srca; 1'b1 |=> pin_irq_group_a_src_o == $past(pad_in_i & a_v); endproperty
  a_srca: assert property (p_srca) else $error("group a source wrong");
  property p_srcb; 1'b1 |=> pin_irq_group_b_src_o == $past(pad_in_i & b_v); endproperty
  a_srcb: assert property (p_srcb) else $error("group b source wrong");
  property p_grp; 1'b1 |=> pin_irq_group_a_o == |$past(pad_in_i & a_v); endproperty
  a_grp: assert property (p_grp) else $error("group a not the or of sources");
  property p_cc; 1'b1 |=> capcmp_in_o == $past(pad_in_i[3:0] & cc_v); endproperty
  a_cc: assert property (p_cc) else $error("capture input wrong");
  property p_ana; 1'b1 |=> adc_d_select_o == $past(ad_v) && rtc_crystal_out_select_o == $past(cfg_ff[4][7]); endproperty
  a_ana: assert property (p_ana) else $error("analog select wrong");
  property p_pwm; cfg_ff[0][5] && !cfg_ff[0][4] && !cfg_ff[0][7] |=> pad_oe_o[0] && pad_out_o[0] == $past(motor_pwm_a_pos_i); endproperty
  a_pwm: assert property (p_pwm) else $error("pwm not on pin 0");
  property p_slave; cfg_ff[2][6] && !cfg_ff[2][7] |=> !pad_out_o[2] && pad_oe_o[2] == $past(slave1_data_low_i); endproperty
  a_slave: assert property (p_slave) else $error("slave data not on pin 2");
  property p_aoe; cfg_ff[1][7] |=> !pad_oe_o[1]; endproperty
  a_aoe: assert property (p_aoe) else $error("analog pin driven");
endmodule
bind port1_low_pin_function_select pin_select_props pin_select_props_i (.clock_i, .reset_n_i, .psel_i, .penable_i,
  .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pstrb_i, .capcmp_in_o, .adc_d_select_o, .pin_irq_group_a_o,
  .motor_pwm_a_pos_i, .slave1_data_low_i, .rtc_crystal_out_select_o, .pad_in_i, .pad_out_o, .pad_oe_o,
  .general_io_in_o, .pin_irq_group_a_src_o, .pin_irq_group_b_src_o);

/* tb/pad_board_model.sv */
// board around the five pads: pull-ups plus an optional external driver
// assumes the block drives a pad only while its enable is high
module pad_board_model (
  input  logic [4:0] pad_out_i, pad_oe_i, ext_oe_i, ext_val_i,
  output logic [4:0] pad_level_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // released pads float up, so open-drain lines idle high
  always_comb begin
    for (int p = 0; p < 5; p++) pad_level_o[p] = pad_oe_i[p] ? pad_out_i[p] : (ext_oe_i[p] ? ext_val_i[p] : 1'b1);
  end
endmodule

/* tb/port1_low_pin_function_select_test.sv */
// self-checking bench for the port 1 low pin function select block
// assumes the board model and the bound checker compile alongside
module port1_low_pin_function_select_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 0, reset_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, motor_pwm_a_pos_i = 0;
  logic motor_pwm_a_neg_i = 0, motor_pwm_b_pos_i = 0, master_clock_low_i = 0, slave1_data_low_i = 0;
  logic slave1_clock_low_i = 0, slave2_clock_low_i = 0, pready_o, pslverr_o, pin_irq_group_a_o, pin_irq_group_b_o;
  logic master_clock_in_o, slave1_data_in_o, slave1_clock_in_o, slave2_clock_in_o, rtc_crystal_out_select_o;
  logic [31:0] paddr_i = 0, pwdata_i = 0, prdata_o;
  logic [3:0]  pstrb_i = 4'hF, capcmp_out_i = 0, capcmp_oe_i = 0, capcmp_in_o, adc_d_select_o;
  logic [4:0]  general_io_out_i = 0, general_io_oe_i = 0, ext_oe = 0, ext_val = 0, pad_in_i, pad_out_o, pad_oe_o;
  logic [4:0]  general_io_in_o, pin_irq_group_a_src_o, pin_irq_group_b_src_o;
  int fails = 0, checked = 0;
  always #20 clock_i = ~clock_i;
  port1_low_pin_function_select port1_low_pin_function_select_i (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pstrb_i(pstrb_i), .pready_o(pready_o), .pslverr_o(pslverr_o), .prdata_o(prdata_o), .pad_in_i(pad_in_i),
    .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o), .general_io_out_i(general_io_out_i),
    .general_io_oe_i(general_io_oe_i), .general_io_in_o(general_io_in_o),
    .pin_irq_group_a_src_o(pin_irq_group_a_src_o), .pin_irq_group_b_src_o(pin_irq_group_b_src_o),
    .pin_irq_group_a_o(pin_irq_group_a_o), .pin_irq_group_b_o(pin_irq_group_b_o),
    .motor_pwm_a_pos_i(motor_pwm_a_pos_i), .motor_pwm_a_neg_i(motor_pwm_a_neg_i),
    .motor_pwm_b_pos_i(motor_pwm_b_pos_i), .capcmp_out_i(capcmp_out_i), .capcmp_oe_i(capcmp_oe_i),
    .capcmp_in_o(capcmp_in_o), .master_clock_low_i(master_clock_low_i), .master_clock_in_o(master_clock_in_o),
    .slave1_data_low_i(slave1_data_low_i), .slave1_data_in_o(slave1_data_in_o),
    .slave1_clock_low_i(slave1_clock_low_i), .slave1_clock_in_o(slave1_clock_in_o),
    .slave2_clock_low_i(slave2_clock_low_i), .slave2_clock_in_o(slave2_clock_in_o),
    .adc_d_select_o(adc_d_select_o), .rtc_crystal_out_select_o(rtc_crystal_out_select_o));
  pad_board_model pad_board_model_i (.pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o), .ext_oe_i(ext_oe),
    .ext_val_i(ext_val), .pad_level_o(pad_in_i));
  task automatic give_verdict;
    if (fails == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; waits on pready under a bound
  task automatic apb(input logic wr, input logic [31:0] addr, data, output logic [31:0] rd, output logic err);
    @(posedge clock_i);
    psel_i <= 1; penable_i <= 0; pwrite_i <= wr; paddr_i <= addr; pwdata_i <= data;
    @(posedge clock_i);
    penable_i <= 1;
    for (int n = 0; n < 8; n++) begin
      @(posedge clock_i);
      if (pready_o === 1'b1) break;
      if (n == 7) begin fails++; give_verdict(); end
    end
    rd = prdata_o; err = pslverr_o;
    psel_i <= 0; penable_i <= 0;
  endtask
  function automatic logic [31:0] addr_of(input int p);
    return {14'h0000, pin_function_pkg::REG_IDX[p], 2'b00};
  endfunction
  task automatic wr(input int p, input logic [7:0] v);
    logic [31:0] d; logic e;
    apb(1'b1, addr_of(p), {24'h000000, v}, d, e);
  endtask
  task automatic rd_chk(input int p, input logic [7:0] exp);
    logic [31:0] d; logic e;
    apb(1'b0, addr_of(p), 32'h00000000, d, e);
    check(d, {24'h000000, exp});
    check(e, 0);
  endtask
  task automatic all_cfg(input logic [7:0] v);
    for (int p = 0; p < 5; p++) wr(p, v);
  endtask
  // pads move one edge after the write, routed inputs one more;
  // read at the third edge, stimulus then changes on that edge
  task automatic settle;
    repeat (3) @(posedge clock_i);
  endtask
  task automatic t_regs;
    logic [31:0] d; logic e;
    for (int p = 0; p < 5; p++) rd_chk(p, 8'h00);
    for (int p = 0; p < 5; p++) begin
      wr(p, 8'hFF);
      rd_chk(p, pin_function_pkg::IMPL_MASK[p]);
      wr(p, 8'h5A);
      rd_chk(p, 8'h5A & pin_function_pkg::IMPL_MASK[p]);
      wr(p, 8'h00);
    end
    pstrb_i <= 4'hE;
    wr(1, 8'h01);
    pstrb_i <= 4'hF;
    rd_chk(1, 8'h00);
    apb(1'b1, 32'h00028174, 32'h000000FF, d, e);
    check(e, 1);
    apb(1'b0, 32'h00028174, 32'h00000000, d, e);
    check(d, 0);
    rd_chk(4, 8'h00);
  endtask
  task automatic t_gio_groups;
    all_cfg(8'h01);
    general_io_oe_i <= 5'h1F; general_io_out_i <= 5'h15;
    settle();
    check(pad_oe_o, 5'h1F);
    check(general_io_in_o, 5'h15);
    general_io_oe_i <= 5'h00; ext_oe <= 5'h1F; ext_val <= 5'h1F;
    wr(0, 8'h02); wr(1, 8'h06); wr(2, 8'h04); wr(3, 8'h06); wr(4, 8'h00);
    settle();
    check(pin_irq_group_a_src_o, 5'h0B);
    check(pin_irq_group_b_src_o, 5'h0E);
    ext_val <= 5'h11;
    settle();
    check({pin_irq_group_a_o, pin_irq_group_b_o, pin_irq_group_b_src_o}, 7'h40);
  endtask
  task automatic t_drive;
    ext_oe <= 5'h00;
    all_cfg(8'h20);
    motor_pwm_a_pos_i <= 1; motor_pwm_b_pos_i <= 1;
    settle();
    check({pad_oe_o, pad_out_o}, 10'h3F5);
    motor_pwm_a_pos_i <= 0; motor_pwm_a_neg_i <= 1; motor_pwm_b_pos_i <= 0;
    settle();
    check(pad_out_o, 5'h0A);
    all_cfg(8'h30);
    capcmp_out_i <= 4'hA; capcmp_oe_i <= 4'hF; master_clock_low_i <= 1;
    settle();
    check({pad_oe_o, pad_out_o}, 10'h3EA);
    check({capcmp_in_o, master_clock_in_o}, 5'h14);
    capcmp_oe_i <= 4'h0; master_clock_low_i <= 0;
    settle();
    check({pad_oe_o, capcmp_in_o, master_clock_in_o}, 10'h01F);
  endtask
  task automatic t_slave_analog;
    all_cfg(8'h40);
    slave1_data_low_i <= 1; slave2_clock_low_i <= 1;
    settle();
    check({pad_oe_o, pad_out_o}, 10'h280);
    check({slave1_data_in_o, slave1_clock_in_o, slave2_clock_in_o}, 3'b010);
    slave1_data_low_i <= 0;
    slave1_clock_low_i <= 1;
    slave2_clock_low_i <= 0;
    settle();
    check({pad_oe_o, slave1_data_in_o, slave1_clock_in_o, slave2_clock_in_o}, 8'h45);
    general_io_oe_i <= 5'h1F;
    all_cfg(8'hB1);
    settle();
    check({pad_oe_o, adc_d_select_o, rtc_crystal_out_select_o}, 10'h01F);
  endtask
  // mid-run reset clears every register, pad enable and analog output; slave1 data and slave2 clock inputs read idle high
  task automatic t_reset;
    @(posedge clock_i);
    reset_n_i <= 0;
    repeat (2) @(posedge clock_i);
    check({pad_oe_o, adc_d_select_o, rtc_crystal_out_select_o, slave1_data_in_o, slave2_clock_in_o}, 11'h003);
    reset_n_i <= 1;
    for (int p = 0; p < 5; p++) rd_chk(p, 8'h00);
  endtask
  initial begin
    repeat (2) @(posedge clock_i);
    reset_n_i <= 1;
    t_regs();
    t_gio_groups();
    t_drive();
    t_slave_analog();
    t_reset();
    give_verdict();
  end
endmodule
